// ==== rtl/epc_top.sv ====
// EPROM programming control: control register, array write capture and
// programming supply switch, with a Wishbone register slave.
// Assumes CPU array accesses and the array read data are on the bus clock;
// the array read data is valid for arr_addr_i in the cycle of arr_rd_i.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: User array is 32256 bytes at 8000h to FDFFh, all programmable.
// R2: The sixteen vector bytes FFF0h to FFFFh are programmable the same way.
// R3: Up to sixteen bytes can be programmed in one supply pulse.
// R4: Control register at index 1Dh, resets to zero, latch bit 2, supply bit 0.
// R5: Programming supply reaches the array exactly while the supply bit is one.
// R6: One write can never raise both latch and supply bits together.
// R7: Supply bit is set only if the latch bit was already one.
// R8: Clearing the latch bit clears the supply bit in the same update.
// R9: With latch set, array writes capture address and data; reads are blocked.
// R10: Software sets latch, writes bytes, holds supply for pulse time, clears latch.
// R11: Multi-byte programming only within one aligned sixteen-byte block.
// R12: Array writes with latch clear change neither array nor capture buffer.
module epc_top
  import epc_pkg::*;
#(
  parameter int PULSE_CYCLES = epc_pkg::PULSE_CYC_DEFAULT
)
(
  // Clock and reset.
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone slave.
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [epc_pkg::WB_AW-1:0]     wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [epc_pkg::WB_DW-1:0]     wb_dat_i,
  output logic [epc_pkg::WB_DW-1:0]          wb_dat_o,
  output logic                               wb_ack_o,
  output logic                               wb_err_o,
  // CPU array accesses.
  input  wire logic                          arr_wr_i,
  input  wire logic                          arr_rd_i,
  input  wire logic [15:0]                   arr_addr_i,
  input  wire logic [7:0]                    arr_wdata_i,
  output logic [7:0]                         arr_rdata_o,
  output logic                               arr_rvalid_o,
  output logic                               arr_rd_blocked_o,
  // EPROM array side.
  input  wire logic [7:0]                    eprom_rdata_i,
  output logic                               eprom_latch_o,
  output logic                               eprom_supply_o,
  output logic [epc_pkg::BASE_W-1:0]         eprom_base_o,
  output logic [8*epc_pkg::BLOCK_BYTES-1:0]  eprom_data_o,
  output logic [epc_pkg::BLOCK_BYTES-1:0]    eprom_mask_o
);

  localparam logic [PULSE_CNT_W-1:0] PULSE_LIMIT = PULSE_CNT_W'(PULSE_CYCLES);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  epc_state_type              state_reg, state_next;
  logic                       ack_reg, ack_next;
  logic                       err_reg, err_next;
  logic [WB_DW-1:0]           rdat_reg, rdat_next;
  logic                       block_err_reg, block_err_next;
  logic [PULSE_CNT_W-1:0]     pulse_cnt_reg, pulse_cnt_next;
  logic                       pulse_met_reg, pulse_met_next;
  logic [7:0]                 ardata_reg, ardata_next;
  logic                       arvalid_reg, arvalid_next;
  logic                       arblock_reg, arblock_next;

  logic                       wb_req;
  logic                       hit_ctrl;
  logic                       hit_status;
  logic                       wr_ctrl;
  logic                       wr_status;
  logic                       new_latch;
  logic                       new_supply;
  logic                       latched;
  logic                       supplying;
  logic [7:0]                 ctrl_view;
  logic [WB_DW-1:0]           status_view;

  logic                       in_array;
  logic [BASE_W-1:0]          blk;
  logic [BLOCK_AW-1:0]        off;
  logic                       cap_wr;
  logic                       buf_clear;
  logic [BASE_W-1:0]          buf_base;
  logic [8*BLOCK_BYTES-1:0]   buf_data;
  logic [BLOCK_BYTES-1:0]     buf_mask;
  logic [COUNT_W-1:0]         buf_count;
  logic                       buf_reject;

  ////////////////////////////////////////////////////////////////////////////////
  // Address classification and capture buffer.
  epc_addr_map u_map (
    .addr_i     (arr_addr_i),
    .in_array_o (in_array),
    .block_o    (blk),
    .offset_o   (off)
  );

  assign latched   = (state_reg != EPC_IDLE);
  assign supplying = (state_reg == EPC_PROGRAM);
  assign cap_wr    = arr_wr_i && in_array && latched; // R9 R12
  assign buf_clear = (state_next == EPC_IDLE);

  epc_prog_buf u_buf (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (buf_clear),
    .wr_i     (cap_wr),
    .block_i  (blk),
    .offset_i (off),
    .data_i   (arr_wdata_i),
    .base_o   (buf_base),
    .data_o   (buf_data),
    .mask_o   (buf_mask),
    .count_o  (buf_count),
    .reject_o (buf_reject)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone decode.
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;

  always_comb begin
    hit_ctrl   = 1'b0;
    hit_status = 1'b0;
    if (wb_adr_i == ADR_PROG_CTRL) begin
      hit_ctrl = 1'b1; // R4
    end else if (wb_adr_i == ADR_PROG_STATUS) begin
      hit_status = 1'b1;
    end
  end

  assign wr_ctrl    = wb_req && wb_we_i && hit_ctrl && wb_sel_i[0];
  assign wr_status  = wb_req && wb_we_i && hit_status && wb_sel_i[0];
  assign new_latch  = wb_dat_i[CTRL_LATCH_BIT];
  assign new_supply = wb_dat_i[CTRL_SUPPLY_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Programming control state.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EPC_IDLE: begin
        // The supply bit is ignored here, so latch and supply never rise together.
        if (wr_ctrl && new_latch) begin
          state_next = EPC_LATCHED; // R6 R7
        end
      end
      EPC_LATCHED: begin
        if (wr_ctrl && !new_latch) begin
          state_next = EPC_IDLE;
        end else if (wr_ctrl && new_supply) begin
          state_next = EPC_PROGRAM; // R7
        end
      end
      EPC_PROGRAM: begin
        if (wr_ctrl && !new_latch) begin
          state_next = EPC_IDLE; // R8
        end else if (wr_ctrl && !new_supply) begin
          state_next = EPC_LATCHED; // R5
        end
      end
      default: begin
        state_next = EPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= EPC_IDLE; // R4
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse timer and status flags.
  // Software owns the pulse length; the timer only reports when the minimum
  // programming time has elapsed, it does not end the pulse itself.
  always_comb begin
    pulse_cnt_next = '0;
    pulse_met_next = 1'b0;
    if (supplying) begin
      pulse_met_next = pulse_met_reg;
      pulse_cnt_next = pulse_cnt_reg;
      if (pulse_cnt_reg != PULSE_LIMIT) begin
        pulse_cnt_next = pulse_cnt_reg + PULSE_CNT_W'(1);
      end
      if (pulse_cnt_next == PULSE_LIMIT) begin
        pulse_met_next = 1'b1; // R10
      end
    end
    // A new reject in the clearing cycle survives the clear.
    block_err_next = block_err_reg;
    if (wr_status && wb_dat_i[ST_BLOCK_ERR_BIT]) begin
      block_err_next = 1'b0;
    end
    if (buf_reject) begin
      block_err_next = 1'b1; // R11
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_cnt_reg <= '0;
      pulse_met_reg <= 1'b0;
      block_err_reg <= 1'b0;
    end else begin
      pulse_cnt_reg <= pulse_cnt_next;
      pulse_met_reg <= pulse_met_next;
      block_err_reg <= block_err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read views and bus answer.
  always_comb begin
    ctrl_view                  = CTRL_RESET;
    ctrl_view[CTRL_LATCH_BIT]  = latched;
    ctrl_view[CTRL_SUPPLY_BIT] = supplying;
    status_view                                  = STATUS_RESET;
    status_view[ST_PULSE_MET_BIT]                = pulse_met_reg;
    status_view[ST_BLOCK_ERR_BIT]                = block_err_reg;
    status_view[ST_HOLDING_BIT]                  = (buf_mask != '0);
    status_view[ST_COUNT_LSB +: COUNT_W]         = buf_count;
    status_view[ST_BASE_LSB +: BASE_W]           = buf_base;
  end

  always_comb begin
    ack_next  = 1'b0;
    err_next  = 1'b0;
    rdat_next = '0;
    if (wb_req && hit_ctrl) begin
      ack_next  = 1'b1;
      rdat_next = {24'h00_0000, ctrl_view}; // R4
    end else if (wb_req && hit_status) begin
      ack_next  = 1'b1;
      rdat_next = status_view;
    end else if (wb_req) begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      err_reg  <= 1'b0;
      rdat_reg <= '0;
    end else begin
      ack_reg  <= ack_next;
      err_reg  <= err_next;
      rdat_reg <= rdat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Array reads.
  // While the buses are latched the array cannot be read, so a read returns
  // zero and is flagged rather than handing back stale cells.
  always_comb begin
    arvalid_next = arr_rd_i && in_array;
    arblock_next = arr_rd_i && in_array && latched; // R9
    ardata_next  = 8'h00;
    if (arr_rd_i && in_array && !latched) begin
      ardata_next = eprom_rdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arvalid_reg <= 1'b0;
      arblock_reg <= 1'b0;
      ardata_reg  <= 8'h00;
    end else begin
      arvalid_reg <= arvalid_next;
      arblock_reg <= arblock_next;
      ardata_reg  <= ardata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign wb_dat_o         = rdat_reg;
  assign wb_ack_o         = ack_reg;
  assign wb_err_o         = err_reg;
  assign arr_rdata_o      = ardata_reg;
  assign arr_rvalid_o     = arvalid_reg;
  assign arr_rd_blocked_o = arblock_reg;
  assign eprom_latch_o    = latched;
  assign eprom_supply_o   = supplying; // R5
  assign eprom_base_o     = buf_base;
  assign eprom_data_o     = buf_data; // R3
  assign eprom_mask_o     = buf_mask;

endmodule

`default_nettype wire

// ==== rtl/epc_pkg.sv ====
// Constants, field layouts and types of the EPROM programming control block.
// Assumes a 10 MHz bus clock and a 32-bit classic Wishbone register bus.
package epc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus.
  localparam int          WB_AW = 8;
  localparam int          WB_DW = 32;
  localparam logic [5:0]  IDX_PROG_CTRL   = 6'h1d;
  localparam logic [5:0]  IDX_PROG_STATUS = 6'h1f;
  localparam logic [7:0]  ADR_PROG_CTRL   = {IDX_PROG_CTRL, 2'b00};
  localparam logic [7:0]  ADR_PROG_STATUS = {IDX_PROG_STATUS, 2'b00};

  ////////////////////////////////////////////////////////////////////////////////
  // Control register fields.
  localparam int          CTRL_LATCH_BIT  = 2;
  localparam int          CTRL_SUPPLY_BIT = 0;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;

  // Status register fields.
  localparam int          ST_PULSE_MET_BIT = 0;
  localparam int          ST_BLOCK_ERR_BIT = 1;
  localparam int          ST_HOLDING_BIT   = 2;
  localparam int          ST_COUNT_LSB     = 8;
  localparam int          ST_BASE_LSB      = 16;
  localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Array map.
  localparam int          USER_BYTES  = 32256;
  localparam logic [15:0] USER_LO     = 16'h8000;
  localparam logic [15:0] USER_HI     = 16'hfdff;
  localparam int          VEC_BYTES   = 16;
  localparam logic [15:0] VEC_LO      = 16'hfff0;
  localparam logic [15:0] VEC_HI      = 16'hffff;
  localparam int          BLOCK_BYTES = 16;
  localparam int          BLOCK_AW    = 4;
  localparam int          BASE_W      = 12;
  localparam int          COUNT_W     = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int          CLK_KHZ               = 10000;
  localparam int          PROGRAM_PULSE_TIME_US = 4000;
  localparam int          PULSE_CYC_DEFAULT     = (PROGRAM_PULSE_TIME_US * CLK_KHZ + 999) / 1000;
  localparam int          PULSE_CNT_W           = 24;

  ////////////////////////////////////////////////////////////////////////////////
  // Programming control states.
  typedef enum logic [2:0] {
    EPC_IDLE    = 3'b001,
    EPC_LATCHED = 3'b010,
    EPC_PROGRAM = 3'b100
  } epc_state_type;

endpackage

// ==== rtl/epc_addr_map.sv ====
// Address classifier for the programmable array space.
// Assumes a 16-bit CPU byte address on the same clock as the caller.
`timescale 1ns/1ps
`default_nettype none

module epc_addr_map
  import epc_pkg::*;
(
  // CPU address.
  input  wire logic [15:0]          addr_i,
  // Classification.
  output logic                      in_array_o,
  output logic [epc_pkg::BASE_W-1:0] block_o,
  output logic [epc_pkg::BLOCK_AW-1:0] offset_o
);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // The bootloader area between the two windows is never programmable here.
  assign in_array_o = in_range(addr_i, USER_LO, USER_HI) // R1
                    | in_range(addr_i, VEC_LO, VEC_HI);  // R2
  assign block_o    = addr_i[15:BLOCK_AW];
  assign offset_o   = addr_i[BLOCK_AW-1:0];

endmodule

`default_nettype wire

// ==== rtl/epc_prog_buf.sv ====
// Programming buffer: up to sixteen bytes of one aligned block.
// Assumes write strobes are single-cycle pulses on the bus clock.
`timescale 1ns/1ps
`default_nettype none

module epc_prog_buf
  import epc_pkg::*;
(
  // Clock and reset.
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Capture side.
  input  wire logic                          clear_i,
  input  wire logic                          wr_i,
  input  wire logic [epc_pkg::BASE_W-1:0]    block_i,
  input  wire logic [epc_pkg::BLOCK_AW-1:0]  offset_i,
  input  wire logic [7:0]                    data_i,
  // Buffer contents.
  output logic [epc_pkg::BASE_W-1:0]         base_o,
  output logic [8*epc_pkg::BLOCK_BYTES-1:0]  data_o,
  output logic [epc_pkg::BLOCK_BYTES-1:0]    mask_o,
  output logic [epc_pkg::COUNT_W-1:0]        count_o,
  output logic                               reject_o
);

  logic [7:0]          byte_reg  [BLOCK_BYTES];
  logic [7:0]          byte_next [BLOCK_BYTES];
  logic [BASE_W-1:0]   base_reg,  base_next;
  logic [BLOCK_BYTES-1:0] mask_reg, mask_next;
  logic                reject_reg, reject_next;
  logic                same_block;

  ////////////////////////////////////////////////////////////////////////////////
  // A write into another block would corrupt the bytes already held, so it is
  // turned away and only flagged.
  assign same_block = (mask_reg == '0) || (block_i == base_reg); // R11

  always_comb begin
    base_next   = base_reg;
    mask_next   = mask_reg;
    reject_next = 1'b0;
    for (int i = 0; i < BLOCK_BYTES; i++) begin
      byte_next[i] = byte_reg[i];
    end
    if (clear_i) begin
      mask_next = '0;
    end else if (wr_i && same_block) begin
      base_next            = block_i;
      mask_next[offset_i]  = 1'b1; // R3
      byte_next[offset_i]  = data_i;
    end else if (wr_i) begin
      reject_next = 1'b1; // R11
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_reg   <= '0;
      mask_reg   <= '0;
      reject_reg <= 1'b0;
      for (int i = 0; i < BLOCK_BYTES; i++) begin
        byte_reg[i] <= 8'h00;
      end
    end else begin
      base_reg   <= base_next;
      mask_reg   <= mask_next;
      reject_reg <= reject_next;
      for (int i = 0; i < BLOCK_BYTES; i++) begin
        byte_reg[i] <= byte_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < BLOCK_BYTES; g++) begin : g_pack
      assign data_o[8*g +: 8] = byte_reg[g];
    end
  endgenerate

  assign base_o   = base_reg;
  assign mask_o   = mask_reg;
  assign reject_o = reject_reg;

  always_comb begin
    count_o = '0;
    for (int i = 0; i < BLOCK_BYTES; i++) begin
      count_o = count_o + COUNT_W'(mask_reg[i]);
    end
  end

endmodule

`default_nettype wire

// ==== verification/epc_top_assertions.sv ====
// Concurrent checks on the ports of the EPROM programming control block.
// Assumes it is bound into every epc_top instance and sees one clock domain.
`timescale 1ns/1ps
`default_nettype none

module epc_top_assertions
  import epc_pkg::*;
(
  // Clock and reset.
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  // Register bus.
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_we_i,
  input wire logic [epc_pkg::WB_AW-1:0]    wb_adr_i,
  input wire logic [3:0]                   wb_sel_i,
  input wire logic [epc_pkg::WB_DW-1:0]    wb_dat_i,
  input wire logic [epc_pkg::WB_DW-1:0]    wb_dat_o,
  input wire logic                         wb_ack_o,
  input wire logic                         wb_err_o,
  // Array side.
  input wire logic                         arr_wr_i,
  input wire logic                         arr_rd_i,
  input wire logic [15:0]                  arr_addr_i,
  input wire logic [7:0]                   arr_rdata_o,
  input wire logic                         arr_rvalid_o,
  input wire logic                         arr_rd_blocked_o,
  input wire logic [7:0]                   eprom_rdata_i,
  input wire logic                         eprom_latch_o,
  input wire logic                         eprom_supply_o,
  input wire logic [epc_pkg::BASE_W-1:0]   eprom_base_o,
  input wire logic [epc_pkg::BLOCK_BYTES-1:0] eprom_mask_o
);
  logic req;
  logic wr_ctrl;
  logic in_arr;

  always_comb begin
    req     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wr_ctrl = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADR_PROG_CTRL);
    in_arr  = (arr_addr_i >= USER_LO && arr_addr_i <= USER_HI) || arr_addr_i >= VEC_LO;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////////
  a_bus_answer: assert property (req |=> (wb_ack_o != wb_err_o) ##1 !wb_ack_o)
    else $error("Bad bus answer.");
  a_unmapped_err: assert property (req && wb_adr_i != ADR_PROG_CTRL
    && wb_adr_i != ADR_PROG_STATUS |=> wb_err_o) else $error("Unmapped access taken.");
  a_ctrl_readback: assert property (req && !wb_we_i && wb_adr_i == ADR_PROG_CTRL
    |=> wb_dat_o == {29'h0, eprom_latch_o, 1'b0, eprom_supply_o}) else $error("Bad readback.");
  a_no_double_set: assert property (wr_ctrl && !eprom_latch_o |=> !eprom_supply_o)
    else $error("Latch and supply rose together.");
  a_supply_needs_latch: assert property ($rose(eprom_supply_o) |-> $past(eprom_latch_o))
    else $error("Supply rose without latch.");
  a_supply_on: assert property (wr_ctrl && eprom_latch_o && wb_dat_i[2] && wb_dat_i[0]
    |=> eprom_supply_o) else $error("Supply not set.");
  a_latch_drop: assert property ($fell(eprom_latch_o) || !eprom_latch_o
    |-> !eprom_supply_o && eprom_mask_o == '0) else $error("Supply or buffer kept.");
  a_read_blocked: assert property (arr_rd_i && eprom_latch_o && in_arr
    |=> arr_rvalid_o && arr_rd_blocked_o && arr_rdata_o == 8'h00)
    else $error("Read not blocked.");
  a_read_pass: assert property (arr_rd_i && !eprom_latch_o && in_arr
    |=> arr_rvalid_o && !arr_rd_blocked_o && arr_rdata_o == $past(eprom_rdata_i))
    else $error("Read data not passed.");
  a_read_outside: assert property (arr_rd_i && !in_arr |=> !arr_rvalid_o)
    else $error("Outside read answered.");
  a_first_capture: assert property (arr_wr_i && eprom_latch_o && in_arr && !wr_ctrl
    && eprom_mask_o == '0 |=> eprom_mask_o == (16'h1 << ($past(arr_addr_i) & 16'hf))
    && eprom_base_o == ($past(arr_addr_i) >> 4)) else $error("Byte not captured.");
  a_block_reject: assert property (arr_wr_i && eprom_latch_o && !wr_ctrl
    && eprom_mask_o != '0 && arr_addr_i[15:4] != eprom_base_o
    |=> $stable(eprom_mask_o) && $stable(eprom_base_o)) else $error("Foreign block captured.");
  a_idle_ignore: assert property (arr_wr_i && !eprom_latch_o |=> eprom_mask_o == '0)
    else $error("Capture without latch.");

  c_supply_set: cover property (wr_ctrl && eprom_latch_o && wb_dat_i[0]);
  c_full_block: cover property (eprom_mask_o == 16'hffff);
  c_read_blocked: cover property (arr_rd_i && eprom_latch_o);
endmodule

bind epc_top epc_top_assertions u_epc_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .wb_err_o, .arr_wr_i, .arr_rd_i, .arr_addr_i, .arr_rdata_o,
  .arr_rvalid_o, .arr_rd_blocked_o, .eprom_rdata_i, .eprom_latch_o, .eprom_supply_o,
  .eprom_base_o, .eprom_mask_o);

`default_nettype wire

// ==== verification/epc_eprom_model.sv ====
// Behavioural model of the EPROM cell array behind the control block.
// Assumes the buffer outputs stay steady while the supply is connected.
`timescale 1ns/1ps
`default_nettype none

module epc_eprom_model
  import epc_pkg::*;
(
  // Clock.
  input  wire logic                               clk_i,
  // Read side.
  input  wire logic [15:0]                        addr_i,
  output logic [7:0]                              rdata_o,
  // Programming side.
  input  wire logic                               supply_i,
  input  wire logic [epc_pkg::BASE_W-1:0]         base_i,
  input  wire logic [8*epc_pkg::BLOCK_BYTES-1:0]  data_i,
  input  wire logic [epc_pkg::BLOCK_BYTES-1:0]    mask_i
);
  logic [7:0] cells [0:65535];

  initial for (int i = 0; i < 65536; i++) cells[i] = 8'hff;

  always_comb rdata_o = cells[addr_i];

  // Cells only lose ones, so a byte hit twice keeps the AND of both values.
  always @(posedge clk_i) begin
    if (supply_i) begin
      for (int i = 0; i < 16; i++) begin
        if (mask_i[i]) cells[{base_i, 4'(i)}] <= cells[{base_i, 4'(i)}] & data_i[8*i +: 8];
      end
    end
  end
endmodule

`default_nettype wire

// ==== verification/tb_eprom_program_control.sv ====
// Self-checking bench for the EPROM programming control block.
// Assumes the array model on the far side and a shortened pulse count.
`timescale 1ns/1ps
`default_nettype none

module tb_eprom_program_control;
  import epc_pkg::*;
  localparam int PULSE = 20;
  localparam logic [7:0] CTL = ADR_PROG_CTRL, STS = ADR_PROG_STATUS;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, wb_err_o, arr_rvalid_o, arr_rd_blocked_o;
  logic        arr_wr_i = 1'b0, arr_rd_i = 1'b0, eprom_latch_o, eprom_supply_o;
  logic [15:0] arr_addr_i = 16'h0000;
  logic [7:0]  arr_wdata_i = 8'h00, arr_rdata_o, eprom_rdata_i;
  logic [11:0] eprom_base_o;
  logic [127:0] eprom_data_o;
  logic [15:0] eprom_mask_o;
  int          errors = 0;
  int          checks_done = 0;

  always #50 clk_i = ~clk_i;

  epc_top #(.PULSE_CYCLES(PULSE)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .arr_wr_i, .arr_rd_i,
    .arr_addr_i, .arr_wdata_i, .arr_rdata_o, .arr_rvalid_o, .arr_rd_blocked_o,
    .eprom_rdata_i, .eprom_latch_o, .eprom_supply_o, .eprom_base_o, .eprom_data_o,
    .eprom_mask_o);
  epc_eprom_model u_cells (.clk_i, .addr_i(arr_addr_i), .rdata_o(eprom_rdata_i),
    .supply_i(eprom_supply_o), .base_i(eprom_base_o), .data_i(eprom_data_o),
    .mask_i(eprom_mask_o));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; a missing answer ends the run rather than hanging it.
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(wb_ack_o || wb_err_o) && n < 16);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 16) begin
      errors++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    bus(1'b1, a, d, 4'hf, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    bus(1'b0, a, 32'h0, 4'hf, q, e);
  endtask

  task automatic aw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    arr_wr_i    <= 1'b1;
    arr_addr_i  <= a;
    arr_wdata_i <= d;
    @(posedge clk_i);
    arr_wr_i <= 1'b0;
  endtask

  task automatic ar(input logic [15:0] a, output logic [31:0] r);
    @(posedge clk_i);
    arr_rd_i   <= 1'b1;
    arr_addr_i <= a;
    @(posedge clk_i);
    arr_rd_i <= 1'b0;
    @(posedge clk_i);
    r = {22'h0, arr_rd_blocked_o, arr_rvalid_o, arr_rdata_o};
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_ctrl_rules;
    logic [31:0] q;
    logic        e;
    rd(CTL, q);
    check(q, 32'h0);
    wr(CTL, 32'hff);
    rd(CTL, q);
    check(q, 32'h4);
    wr(CTL, 32'h5);
    rd(CTL, q);
    check(q, 32'h5);
    check(32'(eprom_supply_o), 32'h1);
    wr(CTL, 32'h1);
    rd(CTL, q);
    check(q, 32'h0);
    wr(CTL, 32'h1);
    rd(CTL, q);
    check(q, 32'h0);
    bus(1'b1, CTL, 32'h4, 4'he, q, e);
    rd(CTL, q);
    check(q, 32'h0);
    bus(1'b0, 8'h00, 32'h0, 4'hf, q, e);
    check(32'(e), 32'h1);
  endtask

  // A full block at the top edge of the user range, plus two refused bytes.
  task automatic t_program;
    logic [31:0] q;
    wr(CTL, 32'h4);
    for (int i = 0; i < 16; i++) aw(16'hfdf0 + 16'(i), 8'ha0 + 8'(i));
    aw(16'h8010, 8'h11);
    aw(16'hfe00, 8'h22);
    @(posedge clk_i);
    check(32'(eprom_mask_o), 32'hffff);
    check(32'(eprom_base_o), 32'hfdf);
    for (int i = 0; i < 16; i++) check(32'(eprom_data_o[8*i +: 8]), 32'ha0 + i);
    ar(16'hfdf0, q);
    check(q, 32'h300);
    rd(STS, q);
    check(q, 32'h0fdf_1006);
    wr(STS, 32'h2);
    wr(CTL, 32'h5);
    repeat (PULSE + 4) @(posedge clk_i);
    rd(STS, q);
    check(q, 32'h0fdf_1005);
    wr(CTL, 32'h0);
    for (int i = 0; i < 16; i++) begin
      ar(16'hfdf0 + 16'(i), q);
      check(q, 32'h1a0 + i);
    end
    ar(16'h8010, q);
    check(q, 32'h1ff);
    ar(16'hfe00, q);
    check(q, 32'h0);
  endtask

  task automatic t_vector_idle;
    logic [31:0] q;
    aw(16'h8020, 8'h00);
    @(posedge clk_i);
    check(32'(eprom_mask_o), 32'h0);
    wr(CTL, 32'h4);
    aw(16'hffff, 8'h5a);
    @(posedge clk_i);
    check(32'(eprom_mask_o), 32'h8000);
    check(32'(eprom_base_o), 32'hfff);
    wr(CTL, 32'h5);
    repeat (PULSE) @(posedge clk_i);
    wr(CTL, 32'h0);
    check(32'(eprom_supply_o), 32'h0);
    ar(16'hffff, q);
    check(q, 32'h15a);
    ar(16'h8020, q);
    check(q, 32'h1ff);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_ctrl_rules();
    t_program();
    t_vector_idle();
    wrap_up();
  end
endmodule

`default_nettype wire
